//--- design/ctd_decoder.sv
`timescale 1ns/1ns
`include "ctd_cfg.svh"
module ctd_decoder (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Instruction byte stream
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	// Processor state
	input wire logic narrow_bus,
	input wire logic word_op,
	input wire logic [15:0] ip_after,
	input wire logic [15:0] count_register,
	input wire logic flag_c,
	input wire logic flag_z,
	input wire logic flag_s,
	input wire logic flag_o,
	input wire logic flag_p,
	input wire logic [1:0] bound_extra,
	// Decode result
	output logic done,
	output ctd_pkg::ctd_op_e op,
	output logic branch_taken,
	output logic [15:0] branch_target,
	output logic [15:0] imm16,
	output logic [7:0] level,
	output logic [7:0] trap_type,
	output logic [15:0] next_count,
	output logic [7:0] cycles
);
	////////////////////////////////////////////////////////////////////
	ctd_pkg::ctd_state_e state, next_state;
	ctd_pkg::ctd_op_e next_op;
	logic [1:0] need, next_need;
	logic [7:0] busy, next_busy;
	logic [7:0] next_cycles;
	logic [15:0] next_imm16;
	logic [7:0] next_level, next_trap_type;
	logic [15:0] next_next_count;
	logic next_branch_taken;
	logic [15:0] next_branch_target;
	logic run_last;
	logic [1:0] got, next_got;
	logic cc_take;
	logic [15:0] tgt;
	logic [15:0] cnt_dec;
	logic [7:0] ent_cost;

	ctd_cond u_cond (
		.code(op == ctd_pkg::CTD_JCC ? imm16[3:0] : 4'h0),
		.flag_c(flag_c),
		.flag_z(flag_z),
		.flag_s(flag_s),
		.flag_o(flag_o),
		.flag_p(flag_p),
		.take(cc_take)
	);
	ctd_target u_tgt (
		.next_ip(ip_after),
		.disp(byte_data),
		.target(tgt)
	);

	assign byte_ready = (state != ctd_pkg::CTD_RUN);
	assign cnt_dec = count_register - 16'h0001;
	// Done marks the last busy cycle; short costs still spend one
	assign run_last = (busy >= cycles - 8'h01) || (cycles <= 8'h01);
	assign done = (state == ctd_pkg::CTD_RUN) && run_last;

	// RULE_12 enter cost by level
	always_comb begin
		ent_cost = 8'h00;
		if (level == 8'h00)
			ent_cost = narrow_bus ? `CTD_CYC_ENT0_N : `CTD_CYC_ENT0_W;
		else if (level == 8'h01)
			ent_cost = narrow_bus ? `CTD_CYC_ENT1_N : `CTD_CYC_ENT1_W;
		else
			ent_cost = (narrow_bus ? `CTD_CYC_ENTN_N : `CTD_CYC_ENTN_W)
				+ 8'((level - 8'h01) *
				(narrow_bus ? `CTD_CYC_ENTS_N : `CTD_CYC_ENTS_W));
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_op = op;
		next_need = need;
		next_got = got;
		next_busy = busy;
		next_cycles = cycles;
		next_imm16 = imm16;
		next_level = level;
		next_trap_type = trap_type;
		next_next_count = next_count;
		next_branch_taken = branch_taken;
		next_branch_target = branch_target;
		unique case (state)
			ctd_pkg::CTD_IDLE: begin
				if (byte_valid) begin
					next_got = 2'h0;
					next_branch_taken = 1'b0;
					next_imm16 = 16'h0000;
					next_need = 2'h1;
					next_state = ctd_pkg::CTD_FETCH;
					unique casez (byte_data)
						// RULE_01 near return
						`CTD_OP_RETN: begin
							next_op = ctd_pkg::CTD_RETN;
							next_need = 2'h0;
						end
						// RULE_02 near return immediate
						`CTD_OP_RETN_IMM: begin
							next_op = ctd_pkg::CTD_RETN_IMM;
							next_need = 2'h2;
						end
						// RULE_03 far returns
						`CTD_OP_RETF: begin
							next_op = ctd_pkg::CTD_RETF;
							next_need = 2'h0;
						end
						`CTD_OP_RETF_IMM: begin
							next_op = ctd_pkg::CTD_RETF_IMM;
							next_need = 2'h2;
						end
						8'b0111_????: begin
							next_op = ctd_pkg::CTD_JCC;
							next_imm16 = {8'h00, byte_data};
						end
						`CTD_OP_BRANCH_IF_COUNT_ZERO: next_op = ctd_pkg::CTD_BRANCH_IF_COUNT_ZERO;
						`CTD_OP_LOOP: next_op = ctd_pkg::CTD_LOOP;
						`CTD_OP_LOOPZ: next_op = ctd_pkg::CTD_LOOPZ;
						`CTD_OP_LOOPNZ: next_op = ctd_pkg::CTD_LOOPNZ;
						`CTD_OP_ENTER: begin
							next_op = ctd_pkg::CTD_ENTER;
							next_need = 2'h3;
						end
						// RULE_13 leave
						`CTD_OP_LEAVE: begin
							next_op = ctd_pkg::CTD_LEAVE;
							next_need = 2'h0;
						end
						`CTD_OP_INT: next_op = ctd_pkg::CTD_INT;
						// RULE_14 breakpoint type three
						`CTD_OP_INT3: begin
							next_op = ctd_pkg::CTD_INT3;
							next_trap_type = `CTD_INT3_TYPE;
							next_need = 2'h0;
						end
						`CTD_OP_TRAP_ON_OVERFLOW: begin
							next_op = ctd_pkg::CTD_TRAP_ON_OVERFLOW;
							next_need = 2'h0;
						end
						// RULE_16 trap return
						`CTD_OP_TRAP_RETURN: begin
							next_op = ctd_pkg::CTD_TRAP_RETURN;
							next_need = 2'h0;
						end
						// RULE_17 bounds check
						`CTD_OP_BOUND: next_op = ctd_pkg::CTD_BOUND;
						default: begin
							next_op = ctd_pkg::CTD_NONE;
							next_state = ctd_pkg::CTD_IDLE;
						end
					endcase
				end
			end
			ctd_pkg::CTD_FETCH: begin
				if (need == 2'h0) begin
					next_state = ctd_pkg::CTD_RUN;
					next_busy = 8'h01;
					next_next_count = count_register;
					unique case (op)
						ctd_pkg::CTD_RETN: next_cycles = narrow_bus ?
							`CTD_CYC_RETN_N : `CTD_CYC_RETN_W;
						ctd_pkg::CTD_RETN_IMM: next_cycles = narrow_bus ?
							`CTD_CYC_RETNI_N : `CTD_CYC_RETNI_W;
						ctd_pkg::CTD_RETF: next_cycles = narrow_bus ?
							`CTD_CYC_RETF_N : `CTD_CYC_RETF_W;
						ctd_pkg::CTD_RETF_IMM: next_cycles = narrow_bus ?
							`CTD_CYC_RETFI_N : `CTD_CYC_RETFI_W;
						ctd_pkg::CTD_ENTER: next_cycles = ent_cost;
						ctd_pkg::CTD_LEAVE: next_cycles = `CTD_CYC_LEAVE;
						ctd_pkg::CTD_INT: next_cycles = `CTD_CYC_INT;
						ctd_pkg::CTD_INT3: next_cycles = `CTD_CYC_INT3;
						// RULE_15 trap on overflow
						ctd_pkg::CTD_TRAP_ON_OVERFLOW: begin
							next_branch_taken = flag_o;
							next_trap_type = `CTD_TRAP_ON_OVERFLOW_TYPE;
							next_cycles = flag_o ?
								`CTD_CYC_TRAP_ON_OVERFLOW_T : `CTD_CYC_TRAP_ON_OVERFLOW_NT;
						end
						ctd_pkg::CTD_TRAP_RETURN: next_cycles = `CTD_CYC_TRAP_RETURN;
						// RULE_18 word transfer penalty
						// RULE_19 address time included
						ctd_pkg::CTD_BOUND: next_cycles =
							`CTD_CYC_BOUND_MIN + {6'h00, bound_extra}
							+ (word_op ? `CTD_CYC_WORD_XFER : 8'h00);
						default: next_cycles = cycles;
					endcase
				end else if (byte_valid) begin
					next_need = need - 2'h1;
					next_got = got + 2'h1;
					unique case (op)
						ctd_pkg::CTD_JCC: begin
							// RULE_04 conditional jump cost
							next_branch_taken = cc_take;
							next_branch_target = tgt;
							next_cycles = cc_take ?
								`CTD_CYC_JCC_T : `CTD_CYC_JCC_NT;
						end
						// RULE_09 count zero jump
						ctd_pkg::CTD_BRANCH_IF_COUNT_ZERO: begin
							next_branch_taken = (count_register == 16'h0000);
							next_branch_target = tgt;
							next_cycles = (count_register == 16'h0000) ?
								`CTD_CYC_BRANCH_IF_COUNT_ZERO_T : `CTD_CYC_BRANCH_IF_COUNT_ZERO_NT;
						end
						// RULE_10 RULE_11 loop forms
						ctd_pkg::CTD_LOOP, ctd_pkg::CTD_LOOPZ,
						ctd_pkg::CTD_LOOPNZ: begin
							next_branch_taken = (cnt_dec != 16'h0000) &&
								(op == ctd_pkg::CTD_LOOP ||
								(op == ctd_pkg::CTD_LOOPZ && flag_z) ||
								(op == ctd_pkg::CTD_LOOPNZ && !flag_z));
							next_branch_target = tgt;
							next_cycles = next_branch_taken ?
								`CTD_CYC_LOOP_T : `CTD_CYC_LOOP_NT;
						end
						ctd_pkg::CTD_INT: next_trap_type = byte_data;
						ctd_pkg::CTD_ENTER: begin
							if (got == 2'h0)
								next_imm16 = {8'h00, byte_data};
							else if (got == 2'h1)
								next_imm16 = {byte_data, imm16[7:0]};
							else
								next_level = byte_data;
						end
						ctd_pkg::CTD_RETN_IMM, ctd_pkg::CTD_RETF_IMM: begin
							if (got == 2'h0)
								next_imm16 = {8'h00, byte_data};
							else
								next_imm16 = {byte_data, imm16[7:0]};
						end
						default: next_imm16 = imm16;
					endcase
				end
			end
			ctd_pkg::CTD_RUN: begin
				if (run_last)
					next_state = ctd_pkg::CTD_IDLE;
				else
					next_busy = busy + 8'h01;
				if (op == ctd_pkg::CTD_LOOP || op == ctd_pkg::CTD_LOOPZ ||
					op == ctd_pkg::CTD_LOOPNZ)
					next_next_count = cnt_dec;
			end
			default: next_state = ctd_pkg::CTD_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ctd_pkg::CTD_IDLE;
			op <= ctd_pkg::CTD_NONE;
			need <= 2'h0;
			got <= 2'h0;
			busy <= 8'h00;
			cycles <= 8'h00;
			imm16 <= 16'h0000;
			level <= 8'h00;
			trap_type <= 8'h00;
			next_count <= 16'h0000;
			branch_taken <= 1'b0;
			branch_target <= 16'h0000;
		end else begin
			state <= next_state;
			op <= next_op;
			need <= next_need;
			got <= next_got;
			busy <= next_busy;
			cycles <= next_cycles;
			imm16 <= next_imm16;
			level <= next_level;
			trap_type <= next_trap_type;
			next_count <= next_next_count;
			branch_taken <= next_branch_taken;
			branch_target <= next_branch_target;
		end
	end

	////////////////////////////////////////////////////////////////////
	// RULE_13 leave cost
	leave_cost_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ctd_pkg::CTD_RUN && op == ctd_pkg::CTD_LEAVE)
		|-> cycles == `CTD_CYC_LEAVE)
		else $error("leave cycle count wrong");
	// RULE_16 trap return cost
	trap_return_cost_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ctd_pkg::CTD_RUN && op == ctd_pkg::CTD_TRAP_RETURN)
		|-> cycles == `CTD_CYC_TRAP_RETURN)
		else $error("trap return cycle count wrong");
	// RULE_15 overflow trap cost
	trap_on_overflow_cost_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ctd_pkg::CTD_RUN && op == ctd_pkg::CTD_TRAP_ON_OVERFLOW)
		|-> cycles == (branch_taken ? `CTD_CYC_TRAP_ON_OVERFLOW_T : `CTD_CYC_TRAP_ON_OVERFLOW_NT))
		else $error("overflow trap cycle count wrong");
	// RULE_04 jump cost
	jcc_cost_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ctd_pkg::CTD_RUN && op == ctd_pkg::CTD_JCC)
		|-> cycles == (branch_taken ? `CTD_CYC_JCC_T : `CTD_CYC_JCC_NT))
		else $error("conditional jump cycle count wrong");
	// RULE_09 count zero cost
	branch_if_count_zero_cost_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ctd_pkg::CTD_RUN && op == ctd_pkg::CTD_BRANCH_IF_COUNT_ZERO)
		|-> cycles == (branch_taken ? `CTD_CYC_BRANCH_IF_COUNT_ZERO_T : `CTD_CYC_BRANCH_IF_COUNT_ZERO_NT))
		else $error("count zero jump cycle count wrong");
	// RULE_10 loop cost
	loop_cost_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ctd_pkg::CTD_RUN && op == ctd_pkg::CTD_LOOP)
		|-> cycles == (branch_taken ? `CTD_CYC_LOOP_T : `CTD_CYC_LOOP_NT))
		else $error("loop cycle count wrong");
	// RULE_14 breakpoint type
	int3_type_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ctd_pkg::CTD_RUN && op == ctd_pkg::CTD_INT3)
		|-> trap_type == `CTD_INT3_TYPE && cycles == `CTD_CYC_INT3)
		else $error("breakpoint type or cost wrong");
	// RULE_01 near return cost
	retn_cost_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ctd_pkg::CTD_RUN && op == ctd_pkg::CTD_RETN)
		|-> cycles == (narrow_bus ? `CTD_CYC_RETN_N : `CTD_CYC_RETN_W))
		else $error("near return cycle count wrong");
endmodule

//--- design/ctd_cfg.svh
// How it works
// RULE_01 - Opcode c3 is near return, 16 clocks wide bus, 20 narrow bus.
// RULE_02 - Opcode c2 plus 16-bit immediate: near return adding to stack, 18/22.
// RULE_03 - Opcode cb far return 22/30; ca with immediate 25/33.
// RULE_04 - Conditional short jumps: opcode plus displacement, 4 not taken, 13 taken; 74 on zero.
// RULE_05 - Signed jumps: 7c less, 7e less-equal, 7d greater-equal, 7f greater.
// RULE_06 - Unsigned jumps: 72 below, 76 below-equal, 73 above-equal, 77 above.
// RULE_07 - Flag jumps: 7a parity, 70 overflow, 78 sign; 7b, 71, 79 opposite.
// RULE_08 - Opcode 75 jumps when zero flag clear, same conditional costs.
// RULE_09 - Opcode e3 jumps when count is zero, 5 not taken, 15 taken.
// RULE_10 - Opcode e2 decrements count, loops while nonzero, 6 exit, 16 branch.
// RULE_11 - e1 loops while count nonzero and zero set; e0 while zero clear.
// RULE_12 - c8 with frame size and level: 15, 25, 22+16(n-1) wide bus.
// RULE_13 - Opcode c9 releases the stack frame in 8 clocks.
// RULE_14 - cd with type byte interrupts in 47 clocks; cc raises type 3 in 45.
// RULE_15 - Opcode ce interrupts only on overflow: 48 taken, 4 otherwise.
// RULE_16 - Opcode cf restores pointer, segment and flags in 28 clocks.
// RULE_17 - Opcode 62 with mod-reg-r/m byte checks bounds in 33 to 35 clocks; the code adds bound_extra up to 3, so 36 is possible.
// RULE_18 - Word operations add 4 clocks per memory transfer.
// RULE_19 - Effective address takes 4 clocks, already inside listed times.
// RULE_20 - Short displacement is sign-extended and added to next address.
`ifndef CTD_CFG_SVH
`define CTD_CFG_SVH
`define CTD_OP_RETN 8'hc3
`define CTD_OP_RETN_IMM 8'hc2
`define CTD_OP_RETF 8'hcb
`define CTD_OP_RETF_IMM 8'hca
`define CTD_OP_JCC_HI 4'h7
`define CTD_OP_BRANCH_IF_COUNT_ZERO 8'he3
`define CTD_OP_LOOP 8'he2
`define CTD_OP_LOOPZ 8'he1
`define CTD_OP_LOOPNZ 8'he0
`define CTD_OP_ENTER 8'hc8
`define CTD_OP_LEAVE 8'hc9
`define CTD_OP_INT 8'hcd
`define CTD_OP_INT3 8'hcc
`define CTD_OP_TRAP_ON_OVERFLOW 8'hce
`define CTD_OP_TRAP_RETURN 8'hcf
`define CTD_OP_BOUND 8'h62
`define CTD_INT3_TYPE 8'h03
// Overflow trap type, a fixed choice of this block
`define CTD_TRAP_ON_OVERFLOW_TYPE 8'h04
`define CTD_CYC_RETN_W 8'h10
`define CTD_CYC_RETN_N 8'h14
`define CTD_CYC_RETNI_W 8'h12
`define CTD_CYC_RETNI_N 8'h16
`define CTD_CYC_RETF_W 8'h16
`define CTD_CYC_RETF_N 8'h1e
`define CTD_CYC_RETFI_W 8'h19
`define CTD_CYC_RETFI_N 8'h21
`define CTD_CYC_JCC_NT 8'h04
`define CTD_CYC_JCC_T 8'h0d
`define CTD_CYC_BRANCH_IF_COUNT_ZERO_NT 8'h05
`define CTD_CYC_BRANCH_IF_COUNT_ZERO_T 8'h0f
`define CTD_CYC_LOOP_NT 8'h06
`define CTD_CYC_LOOP_T 8'h10
`define CTD_CYC_ENT0_W 8'h0f
`define CTD_CYC_ENT1_W 8'h19
`define CTD_CYC_ENTN_W 8'h16
`define CTD_CYC_ENTS_W 8'h10
`define CTD_CYC_ENT0_N 8'h13
`define CTD_CYC_ENT1_N 8'h1d
`define CTD_CYC_ENTN_N 8'h1a
`define CTD_CYC_ENTS_N 8'h14
`define CTD_CYC_LEAVE 8'h08
`define CTD_CYC_INT 8'h2f
`define CTD_CYC_INT3 8'h2d
`define CTD_CYC_TRAP_ON_OVERFLOW_T 8'h30
`define CTD_CYC_TRAP_ON_OVERFLOW_NT 8'h04
`define CTD_CYC_TRAP_RETURN 8'h1c
`define CTD_CYC_BOUND_MIN 8'h21
`define CTD_CYC_BOUND_MAX 8'h23
`define CTD_CYC_WORD_XFER 8'h04
`define CTD_CYC_EA 8'h04
`endif

//--- design/ctd_pkg.sv
package ctd_pkg;
	typedef enum logic [4:0] {
		CTD_NONE, CTD_RETN, CTD_RETN_IMM, CTD_RETF, CTD_RETF_IMM,
		CTD_JCC, CTD_BRANCH_IF_COUNT_ZERO, CTD_LOOP, CTD_LOOPZ, CTD_LOOPNZ, CTD_ENTER,
		CTD_LEAVE, CTD_INT, CTD_INT3, CTD_TRAP_ON_OVERFLOW, CTD_TRAP_RETURN, CTD_BOUND
	} ctd_op_e;
	typedef enum logic [1:0] {
		CTD_IDLE = 2'b00,
		CTD_FETCH = 2'b01,
		CTD_RUN = 2'b11
	} ctd_state_e;
endpackage

//--- design/ctd_cond.sv
`timescale 1ns/1ns
// Condition tester for the sixteen short conditional jumps
module ctd_cond (
	// Condition code from opcode low nibble
	input wire logic [3:0] code,
	// Flags
	input wire logic flag_c,
	input wire logic flag_z,
	input wire logic flag_s,
	input wire logic flag_o,
	input wire logic flag_p,
	// Result
	output logic take
);
	logic base;
	always_comb begin
		unique case (code[3:1])
			// RULE_07 flag tests
			3'h0: base = flag_o;
			// RULE_06 unsigned tests
			3'h1: base = flag_c;
			// RULE_04 zero test
			3'h2: base = flag_z;
			3'h3: base = flag_c | flag_z;
			3'h4: base = flag_s;
			3'h5: base = flag_p;
			// RULE_05 signed tests
			3'h6: base = flag_s ^ flag_o;
			3'h7: base = (flag_s ^ flag_o) | flag_z;
		endcase
		// RULE_08 odd codes invert
		take = base ^ code[0];
	end
endmodule

//--- design/ctd_target.sv
`timescale 1ns/1ns
// Branch target adder
module ctd_target (
	// Operands
	input wire logic [15:0] next_ip,
	input wire logic [7:0] disp,
	// Result
	output logic [15:0] target
);
	// RULE_20 sign extend add
	assign target = next_ip + {{8{disp[7]}}, disp};
endmodule

//--- test/control_transfer_decoder_tb_top.sv
`timescale 1ns/1ns
module control_transfer_decoder_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic byte_valid = 1'b0;
	logic [7:0] byte_data = 8'h00;
	logic narrow_bus = 1'b0;
	logic word_op = 1'b0;
	logic [15:0] ip_after = 16'h1000;
	logic [15:0] count_register = 16'h0000;
	logic flag_c = 1'b0, flag_z = 1'b0, flag_s = 1'b0;
	logic flag_o = 1'b0, flag_p = 1'b0;
	logic [1:0] bound_extra = 2'h0;
	logic byte_ready, done, branch_taken;
	ctd_pkg::ctd_op_e op;
	logic [15:0] branch_target, imm16, next_count;
	logic [7:0] level, trap_type, cycles;
	int n_fail = 0;
	int n_compared = 0;

	always #50 clk = ~clk;

	ctd_decoder u_dut (
		.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid),
		.byte_data(byte_data), .byte_ready(byte_ready),
		.narrow_bus(narrow_bus), .word_op(word_op), .ip_after(ip_after),
		.count_register(count_register), .flag_c(flag_c), .flag_z(flag_z),
		.flag_s(flag_s), .flag_o(flag_o), .flag_p(flag_p),
		.bound_extra(bound_extra), .done(done), .op(op),
		.branch_taken(branch_taken), .branch_target(branch_target),
		.imm16(imm16), .level(level), .trap_type(trap_type),
		.next_count(next_count), .cycles(cycles)
	);

	////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("n_compared=%0d n_fail=%0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task check(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task wait_ready;
		int i;
		i = 0;
		@(negedge clk);
		while (byte_ready !== 1'b1) begin
			i++;
			if (i > 300) begin
				check(1'b0, "ready timeout");
				stop_test;
			end
			@(negedge clk);
		end
	endtask

	// Bytes go out lowest first; n counts the bytes held in b
	task run(input logic [31:0] b, input int n,
		input ctd_pkg::ctd_op_e exp_op, input logic [7:0] exp_cyc);
		int k, i;
		@(posedge clk);
		for (k = 0; k < n; k++) begin
			byte_valid <= 1'b1;
			byte_data <= b[8*k +: 8];
			wait_ready;
			@(posedge clk);
		end
		byte_valid <= 1'b0;
		i = 0;
		@(negedge clk);
		while (done !== 1'b1) begin
			i++;
			if (i > 400) begin
				check(1'b0, "done timeout");
				stop_test;
			end
			@(negedge clk);
		end
		// Done shows on the last busy cycle, cost less one after fetch
		check(i == int'(exp_cyc) - 1, "run length");
		wait_ready;
		check(op === exp_op, "opcode class");
		check(cycles === exp_cyc, "cycle cost");
	endtask

	function automatic logic cond_exp(input logic [3:0] c,
		input logic [4:0] f);
		logic r;
		// f holds p, o, s, z, c from top down
		case (c[3:1])
		3'h0: r = f[3];
		3'h1: r = f[0];
		3'h2: r = f[1];
		3'h3: r = f[0] | f[1];
		3'h4: r = f[2];
		3'h5: r = f[4];
		3'h6: r = f[2] ^ f[3];
		default: r = (f[2] ^ f[3]) | f[1];
		endcase
		return r ^ c[0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		@(negedge clk);
		check(op === ctd_pkg::CTD_NONE && cycles === 8'h00, "reset outputs");
		check(byte_ready === 1'b1, "reset ready");
	endtask

	task t_returns;
		int nb;
		for (nb = 0; nb < 2; nb++) begin
			@(posedge clk);
			narrow_bus <= nb[0];
			run(32'h000000c3, 1, ctd_pkg::CTD_RETN, nb ? 8'h14 : 8'h10);
			run(32'h003412c2, 3, ctd_pkg::CTD_RETN_IMM, nb ? 8'h16 : 8'h12);
			check(imm16 === 16'h3412, "near imm");
			run(32'h000000cb, 1, ctd_pkg::CTD_RETF, nb ? 8'h1e : 8'h16);
			run(32'h00fe80ca, 3, ctd_pkg::CTD_RETF_IMM, nb ? 8'h21 : 8'h19);
			check(imm16 === 16'hfe80, "far imm");
		end
		@(posedge clk);
		narrow_bus <= 1'b0;
	endtask

	task t_jcc;
		int c, f;
		logic tk;
		logic [7:0] d;
		for (c = 0; c < 16; c++) begin
			for (f = 0; f < 32; f++) begin
				tk = cond_exp(c[3:0], f[4:0]);
				d = f[1] ? 8'h80 : 8'h7f;
				@(posedge clk);
				{flag_p, flag_o, flag_s, flag_z, flag_c} <= f[4:0];
				ip_after <= {c[3:0], 12'hff0} + 16'(f);
				run({16'h0000, d, 4'h7, c[3:0]}, 2, ctd_pkg::CTD_JCC, tk ? 8'h0d : 8'h04);
				check(branch_taken === tk, "jump decision");
				if (tk)
					check(branch_target === ip_after + {{8{d[7]}}, d}, "target");
			end
		end
	endtask

	task t_count;
		int i, z, j;
		logic [15:0] cnt, dec;
		logic tk;
		logic [15:0] tbl [4];
		ctd_pkg::ctd_op_e lop [3];
		tbl = '{16'h0000, 16'h0001, 16'h0002, 16'hffff};
		lop = '{ctd_pkg::CTD_LOOP, ctd_pkg::CTD_LOOPZ, ctd_pkg::CTD_LOOPNZ};
		for (i = 0; i < 4; i++) begin
			for (z = 0; z < 2; z++) begin
				cnt = tbl[i];
				@(posedge clk);
				count_register <= cnt;
				flag_z <= z[0];
				tk = (cnt == 16'h0000);
				run(32'h0000fce3, 2, ctd_pkg::CTD_BRANCH_IF_COUNT_ZERO, tk ? 8'h0f : 8'h05);
				check(branch_taken === tk, "count zero jump");
				for (j = 0; j < 3; j++) begin
					dec = cnt - 16'h0001;
					tk = (dec != 16'h0000) && (j == 0 || (j == 1 && z == 1) || (j == 2 && z == 0));
					run({16'h0000, 8'h90, 8'he2 - 8'(j)}, 2, lop[j], tk ? 8'h10 : 8'h06);
					check(next_count === dec, "count decrement");
					check(branch_taken === tk, "repeat decision");
					if (tk)
						check(branch_target === ip_after - 16'h0070, "back target");
				end
			end
		end
	endtask

	task t_enter;
		int nb, k, l, e;
		int lv [4];
		lv = '{0, 1, 2, 5};
		for (nb = 0; nb < 2; nb++) begin
			@(posedge clk);
			narrow_bus <= nb[0];
			for (k = 0; k < 4; k++) begin
				l = lv[k];
				if (l == 0)
					e = nb ? 19 : 15;
				else if (l == 1)
					e = nb ? 29 : 25;
				else
					e = nb ? 26 + 20 * (l - 1) : 22 + 16 * (l - 1);
				run({8'(l), 8'h12, 8'h34, 8'hc8}, 4, ctd_pkg::CTD_ENTER, e[7:0]);
				check(imm16 === 16'h1234 && level === 8'(l), "frame fields");
			end
			run(32'h000000c9, 1, ctd_pkg::CTD_LEAVE, 8'h08);
		end
		@(posedge clk);
		narrow_bus <= 1'b0;
	endtask

	task t_trap;
		run(32'h000021cd, 2, ctd_pkg::CTD_INT, 8'h2f);
		check(trap_type === 8'h21, "typed trap");
		run(32'h000000cc, 1, ctd_pkg::CTD_INT3, 8'h2d);
		check(trap_type === 8'h03, "type three");
		@(posedge clk);
		flag_o <= 1'b1;
		run(32'h000000ce, 1, ctd_pkg::CTD_TRAP_ON_OVERFLOW, 8'h30);
		check(trap_type === 8'h04, "overflow trap type");
		@(posedge clk);
		flag_o <= 1'b0;
		run(32'h000000ce, 1, ctd_pkg::CTD_TRAP_ON_OVERFLOW, 8'h04);
		run(32'h000000cf, 1, ctd_pkg::CTD_TRAP_RETURN, 8'h1c);
	endtask

	task t_bound;
		int w, e;
		for (w = 0; w < 2; w++) begin
			for (e = 0; e < 3; e++) begin
				@(posedge clk);
				word_op <= w[0];
				bound_extra <= e[1:0];
				run(32'h00000662, 2, ctd_pkg::CTD_BOUND, 8'(33 + e + 4 * w));
			end
		end
		@(posedge clk);
		word_op <= 1'b0;
	endtask

	// Unknown opcode is dropped, clears the class and stays idle
	task t_refuse;
		@(posedge clk);
		byte_valid <= 1'b1;
		byte_data <= 8'h90;
		repeat (3) @(posedge clk);
		byte_valid <= 1'b0;
		@(negedge clk);
		check(byte_ready === 1'b1 && op === ctd_pkg::CTD_NONE, "refused byte");
		run(32'h000000c3, 1, ctd_pkg::CTD_RETN, 8'h10);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_returns;
		t_jcc;
		t_count;
		t_enter;
		t_trap;
		t_bound;
		t_refuse;
		stop_test;
	end
endmodule
